// [common/athseq_pkg.sv]
// package: constants and state encoding for the track/hold sequencer
package athseq_pkg;
  // tracking interval before each internally started conversion in low-power mode, in converter clocks
  localparam int unsigned LP_TRACK_CLKS   = 3;
  // default conversion length in converter clocks
  localparam int unsigned CONV_CLKS       = 16;
  localparam int unsigned CNT_W           = 8;
  localparam logic        LP_SEL_RST      = 1'b0;

  typedef enum logic [1:0] {
    ATH_IDLE,
    ATH_TRACK,
    ATH_CONV,
    ATH_WAIT_EDGE
  } athseq_state_t;

  typedef struct packed {
    athseq_state_t st;
    logic [7:0]    cnt;
    logic          lp_mode;
    logic          strobe_prev;
    logic          conv_done;
  } athseq_regs_t;
endpackage

// [hdl/athseq_top.sv]
// module: track-and-hold sequencer for a successive-approximation converter
//
// What this block does
// [RULE1] default mode: track whenever not converting
// [RULE2] select bit chooses low-power track-and-hold
// [RULE3] low-power: track 3 clocks before converting
// [RULE4] low-power with external strobe: track only while strobe low
// [RULE5] external strobe: convert on strobe rising edge
// [RULE6] standby or sleep disables tracking entirely
// [RULE7] software should pick low-power when retuning inputs
// [RULE8] select change applies from next start
`timescale 1ns/1ps
module athseq_top
  import athseq_pkg::*;
#(
  parameter int unsigned TRACK_CLKS = LP_TRACK_CLKS,
  parameter int unsigned CONV_LEN   = CONV_CLKS
) (
  input  wire logic clk,                      // converter clock, 20 MHz
  input  wire logic sys_rst,                  // synchronous reset, active high
  input  wire logic lowpower_track_select,    // 1 selects low-power track-and-hold
  input  wire logic ext_strobe_sel,           // 1: external strobe starts conversions
  input  wire logic start_pulse,              // internal start-of-conversion, one cycle
  input  wire logic external_convert_strobe,  // external convert strobe pin
  input  wire logic chip_standby,             // chip in standby or sleep
  output logic      track_en,                 // sampling switch closed
  output logic      conv_busy,                // conversion proper running
  output logic      conv_done                 // one-cycle pulse at end of conversion
);

  // ----------------------------------------------------------------
  // state registers
  // ----------------------------------------------------------------
  athseq_regs_t r_r;
  athseq_regs_t r_nxt;
  logic         strobe_rise;
  logic         strobe_fall;
  logic         start_evt;

  // strobe edge detection; the pin is taken as synchronous to clk
  assign strobe_rise = external_convert_strobe & ~r_r.strobe_prev;
  assign strobe_fall = ~external_convert_strobe & r_r.strobe_prev;
  assign start_evt   = ext_strobe_sel ? strobe_rise : start_pulse;

  // ----------------------------------------------------------------
  // sequencing
  // ----------------------------------------------------------------
  always_comb begin
    r_nxt             = r_r;
    r_nxt.strobe_prev = external_convert_strobe;
    r_nxt.conv_done   = 1'b0;
    case (r_r.st)
      ATH_IDLE: begin
        // the mode bit is latched only here, so a running conversion is untouched
        r_nxt.lp_mode = lowpower_track_select; // see [RULE8] [RULE2]
        if (chip_standby) begin
          r_nxt.st = ATH_IDLE;
        end else if (lowpower_track_select && ext_strobe_sel) begin
          // strobe low means the source wants tracking
          if (strobe_fall || !external_convert_strobe) begin
            r_nxt.st = ATH_WAIT_EDGE; // see [RULE4]
          end
        end else if (start_evt) begin
          r_nxt.cnt = 8'h00;
          r_nxt.st  = lowpower_track_select ? ATH_TRACK : ATH_CONV; // see [RULE3] [RULE1]
        end
      end
      ATH_WAIT_EDGE: begin
        // the strobe edge ends tracking and starts the conversion directly
        if (chip_standby) begin
          r_nxt.st = ATH_IDLE;
        end else if (strobe_rise) begin
          r_nxt.cnt = 8'h00;
          r_nxt.st  = ATH_CONV; // see [RULE5]
        end
      end
      ATH_TRACK: begin
        // fixed tracking interval before the conversion proper
        if (r_r.cnt == 8'(TRACK_CLKS - 1)) begin
          r_nxt.cnt = 8'h00;
          r_nxt.st  = ATH_CONV; // see [RULE3]
        end else begin
          r_nxt.cnt = r_r.cnt + 8'h01;
        end
      end
      ATH_CONV: begin
        if (r_r.cnt == 8'(CONV_LEN - 1)) begin
          r_nxt.cnt       = 8'h00;
          r_nxt.conv_done = 1'b1;
          r_nxt.st        = ATH_IDLE;
        end else begin
          r_nxt.cnt = r_r.cnt + 8'h01;
        end
      end
      default: begin
        r_nxt.st = ATH_IDLE;
      end
    endcase
  end

  // strobe history resets high, the idle level of the pin, so no false rising
  // edge follows reset; the mode bit resets to continuous tracking
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      r_r.st          <= ATH_IDLE;
      r_r.cnt         <= 8'h00;
      r_r.lp_mode     <= LP_SEL_RST;
      r_r.strobe_prev <= 1'b1;
      r_r.conv_done   <= 1'b0;
    end else begin
      r_r <= r_nxt;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // standby overrides every mode; low-power idle keeps the switch open to save power
  always_comb begin
    track_en = 1'b0;
    if (!chip_standby) begin // see [RULE6]
      case (r_r.st)
        ATH_IDLE:      track_en = ~r_r.lp_mode & ~lowpower_track_select; // see [RULE1]
        ATH_TRACK:     track_en = 1'b1; // see [RULE3]
        ATH_WAIT_EDGE: track_en = ~external_convert_strobe; // see [RULE4]
        default:       track_en = 1'b0;
      endcase
    end
  end
  assign conv_busy = (r_r.st == ATH_CONV);
  assign conv_done = r_r.conv_done;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence s_lp_start;
    (r_r.st == ATH_IDLE) && !chip_standby && lowpower_track_select && !ext_strobe_sel
      && start_pulse;
  endsequence

  sequence s_track_three;
    (r_r.st == ATH_TRACK) [*3] ##1 (r_r.st == ATH_CONV);
  endsequence

  AST_LP_TRACK_3: assert property (@(posedge clk) disable iff (sys_rst) // see [RULE3]
    s_lp_start |=> s_track_three)
    else $error("low-power tracking interval not three clocks");

  AST_DEF_TRACK: assert property (@(posedge clk) disable iff (sys_rst) // see [RULE1]
    ((r_r.st == ATH_IDLE) && !chip_standby && !r_r.lp_mode && !lowpower_track_select)
      |-> track_en)
    else $error("default mode not tracking while idle");

  AST_DEF_START: assert property (@(posedge clk) disable iff (sys_rst) // see [RULE2]
    ((r_r.st == ATH_IDLE) && !chip_standby && !lowpower_track_select && !ext_strobe_sel
      && start_pulse) |=> conv_busy)
    else $error("default mode start did not convert at once");

  // checked over every state of the strobe-driven low-power mode, not only the wait state
  AST_STROBE_LOW: assert property (@(posedge clk) disable iff (sys_rst) // see [RULE4]
    (r_r.lp_mode && lowpower_track_select && ext_strobe_sel && track_en)
      |-> !external_convert_strobe)
    else $error("tracking while strobe high");

  AST_STROBE_EDGE: assert property (@(posedge clk) disable iff (sys_rst) // see [RULE5]
    ((r_r.st == ATH_WAIT_EDGE) && !chip_standby && strobe_rise) |=> conv_busy && !track_en)
    else $error("conversion did not begin on strobe rise");

  AST_STANDBY: assert property (@(posedge clk) disable iff (sys_rst) // see [RULE6]
    chip_standby |-> !track_en)
    else $error("tracking during standby");

  AST_MODE_HOLD: assert property (@(posedge clk) disable iff (sys_rst) // see [RULE8]
    (conv_busy && $past(conv_busy)) |-> $stable(r_r.lp_mode))
    else $error("mode changed during conversion");

  AST_CONV_LEN: assert property (@(posedge clk) disable iff (sys_rst) // see [RULE3]
    $rose(conv_busy) |-> conv_busy [*8])
    else $error("conversion ended too early");

  AST_DONE: assert property (@(posedge clk) disable iff (sys_rst) // see [RULE5]
    $fell(conv_busy) |-> conv_done)
    else $error("end of conversion not flagged");

  // ----------------------------------------------------------------
  // further checks: standby, done pulse, mode latching
  // ----------------------------------------------------------------
  // a standby request while waiting for the strobe drops back to idle; a strobe still
  // low once standby ends sends the sequencer straight back to the wait
  sequence s_wait_standby;
    (r_r.st == ATH_WAIT_EDGE) && chip_standby;
  endsequence

  AST_STBY_WAIT: assert property (@(posedge clk) disable iff (sys_rst) // see [RULE6]
    s_wait_standby |=> (r_r.st == ATH_IDLE))
    else $error("standby did not leave strobe wait");

  // the done flag is a single-cycle pulse
  AST_DONE_PULSE: assert property (@(posedge clk) disable iff (sys_rst) // see [RULE3]
    conv_done |=> !conv_done)
    else $error("end of conversion flag held too long");

  // low-power idle keeps the sampling switch open, saving power between conversions
  AST_LP_IDLE_OFF: assert property (@(posedge clk) disable iff (sys_rst) // see [RULE2]
    ((r_r.st == ATH_IDLE) && lowpower_track_select) |-> !track_en)
    else $error("low-power idle still tracking");

  // a start in low-power mode latches the mode that the sequence then follows
  AST_MODE_LATCH: assert property (@(posedge clk) disable iff (sys_rst) // see [RULE8]
    s_lp_start |=> r_r.lp_mode)
    else $error("low-power start did not latch mode");

endmodule

// [tb/athseq_strobe_src.sv]
// strobe source model: the external convert-start pin, idle high
`timescale 1ns/1ps
module athseq_strobe_src (
  input  wire logic clk,     // converter clock
  output logic      strobe   // convert strobe pin
);
  initial strobe = 1'b1;
  // hold low for the tracking the input needs
  task automatic hold_low(input int n);
    @(negedge clk) strobe = 1'b0;
    repeat (n) @(negedge clk);
  endtask
  // the rising edge asks for the conversion
  task automatic release_hi();
    strobe = 1'b1;
  endtask
endmodule

// [tb/athseq_top_test.sv]
// testbench: scenario tasks for the track/hold sequencer
`timescale 1ns/1ps
module athseq_top_test;
  import athseq_pkg::*;
  localparam int unsigned CONV_T = 16;
  logic clk, sys_rst, lp_sel, ext_sel, start, stby;
  wire  strobe, track_en, conv_busy, conv_done;
  wire  [2:0] obs = {conv_done, conv_busy, track_en};
  int   n_errors = 0;
  int   tests_run = 0;
  int   n;
  athseq_top #(.TRACK_CLKS(LP_TRACK_CLKS), .CONV_LEN(CONV_T)) u_athseq_top (
    .clk(clk), .sys_rst(sys_rst), .lowpower_track_select(lp_sel), .ext_strobe_sel(ext_sel),
    .start_pulse(start), .external_convert_strobe(strobe), .chip_standby(stby),
    .track_en(track_en), .conv_busy(conv_busy), .conv_done(conv_done));
  athseq_strobe_src u_athseq_strobe_src (.clk(clk), .strobe(strobe));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  // count cycles a flag stays high; bounded so a stuck flag still ends the run
  task automatic run_len(input int b, output int cnt);
    cnt = 0;
    while (obs[b] === 1'b1 && cnt < 40) begin
      cnt++;
      @(negedge clk);
    end
    if (cnt >= 40) begin
      n_errors++;
      give_verdict();
    end
  endtask
  task automatic pulse_start();
    start = 1'b1;
    @(negedge clk) start = 1'b0;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_standby();
    check(track_en, 1'b1);
    stby = 1'b1;
    #1 check(track_en, 1'b0);
    pulse_start();
    check(conv_busy, 1'b0);
    stby = 1'b0;
    #1 check(track_en, 1'b1);
    @(negedge clk);
    $display("standby test done");
  endtask
  task automatic t_default();
    pulse_start();
    check(track_en, 1'b0);
    lp_sel = 1'b1; // mid-conversion, must not stretch or cut it
    run_len(1, n);
    check(8'(n), 8'(CONV_T));
    check(conv_done, 1'b1);
    check(track_en, 1'b0);
    @(negedge clk);
    $display("default test done");
  endtask
  // low-power mode: fixed tracking interval, then conversion length and done pulse
  task automatic t_lowpower();
    pulse_start();
    run_len(0, n);
    check(8'(n), 8'(LP_TRACK_CLKS));
    check(conv_busy, 1'b1);
    run_len(1, n);
    check(8'(n), 8'(CONV_T));
    run_len(2, n);
    check(8'(n), 8'h01);
    $display("low-power test done");
  endtask
  task automatic t_external();
    ext_sel = 1'b1;
    u_athseq_strobe_src.hold_low(2);
    check(track_en, 1'b1);
    stby = 1'b1;
    #1 check(track_en, 1'b0);
    @(negedge clk);
    stby = 1'b0;
    @(negedge clk);
    check(track_en, 1'b1);
    u_athseq_strobe_src.release_hi();
    #1 check(track_en, 1'b0);
    @(negedge clk);
    check(conv_busy, 1'b1);
    run_len(1, n);
    check(8'(n), 8'(CONV_T));
    $display("external test done");
  endtask
  // strobe-started conversions in default mode: track while idle, convert at once
  task automatic t_ext_default();
    lp_sel = 1'b0;
    u_athseq_strobe_src.hold_low(1);
    check(track_en, 1'b1);
    u_athseq_strobe_src.release_hi();
    @(negedge clk);
    check(conv_busy, 1'b1);
    check(track_en, 1'b0);
    run_len(1, n);
    check(8'(n), 8'(CONV_T));
    $display("external default test done");
  endtask
  initial begin
    sys_rst = 1'b1;
    lp_sel = 1'b0;
    ext_sel = 1'b0;
    start = 1'b0;
    stby = 1'b0;
    repeat (12) @(negedge clk);
    sys_rst = 1'b0;
    @(negedge clk);
    t_standby();
    t_default();
    t_lowpower();
    t_external();
    t_ext_default();
    give_verdict();
  end
endmodule
